// file: logic/srac_host.sv
// Host controller that sequences reads and writes of an asynchronous SRAM.
// Assumes the SRAM pins are wired straight out and the board resolves the data bus.
//
// Operation
// - Write starts when both selects and strobe active
// - Data set up 25 ns, held past end
// - Select, address, strobe 35 ns; cycle 45 ns
// - Address set before start, held past end; here address changes on the same edge as selects and strobe
// - Write strobe stays high during reads
// - Host drives only after memory floats
// - Address valid no later than select
// - Deselect before retention, wait 45 ns after
`timescale 1ns/1ps
module srac_host
	import srac_pkg::*;
#(
	parameter int ADDR_W = srac_pkg::SRAC_ADDR_W,
	parameter int DATA_W = srac_pkg::SRAC_DATA_W
) (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Command port
	input wire logic req_i,
	input wire logic write_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	output logic ready_o,
	output logic [DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	// Retention control
	input wire logic sleep_i,
	output logic asleep_o,
	// SRAM pins
	output logic [ADDR_W-1:0] mem_addr_o,
	output logic select_low_active_n_o,
	output logic select_high_active_o,
	output logic write_strobe_n_o,
	output logic output_enable_n_o,
	input wire logic [DATA_W-1:0] mem_data_i,
	output logic [DATA_W-1:0] mem_data_o,
	output logic mem_data_oe_o
);
	import srac_pkg::*;

	typedef struct packed {
		srac_state_t state;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic sel_n;
		logic sel;
		logic we_n;
		logic oe_n;
		logic data_oe;
		logic [DATA_W-1:0] sync1;
		logic [DATA_W-1:0] sync2;
	} srac_host_t;

	// Reset leaves the memory deselected with every strobe inactive
	localparam srac_host_t SRAC_RST = '{
		state: SRAC_IDLE,
		sel_n: 1'b1,
		we_n: 1'b1,
		oe_n: 1'b1,
		default: '0
	};

	srac_host_t r;
	srac_host_t next_r;
	logic t_load;
	logic [SRAC_CNT_W-1:0] t_val;
	logic t_done;

	initial begin
		if (ADDR_W < 1 || DATA_W < 1) begin
			$error("srac_host: widths must be at least 1");
		end
		if (SRAC_READ_CYC > (1 << SRAC_CNT_W) || SRAC_RECOVERY_CYC > (1 << SRAC_CNT_W)) begin
			$error("srac_host: phase timer too narrow");
		end
		if (SRAC_STROBE_CYC + SRAC_HOLD_CYC + SRAC_FLOAT_CYC
			< (SRAC_WRITE_CYCLE_MIN_NS + SRAC_CLK_NS - 1) / SRAC_CLK_NS) begin
			$error("srac_host: write cycle shorter than minimum");
		end
	end

	srac_timer #(
		.CNT_W(SRAC_CNT_W)
	) u_timer (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.load_i(t_load),
		.value_i(t_val),
		.done_o(t_done)
	);

	// Sequencer: one access at a time, bus turnaround after every access
	always_comb begin
		next_r = r;
		next_r.rvalid = 1'b0;
		next_r.sync1 = mem_data_i; // Pin data is asynchronous to us
		next_r.sync2 = r.sync1;
		t_load = 1'b0;
		t_val = '0;
		case (r.state)
			SRAC_IDLE: begin
				if (sleep_i) begin
					// Already deselected here, so retention may begin at once
					next_r.state = SRAC_SLEEP;
				end else if (req_i) begin
					// Address, selects and strobe all change on the same edge
					next_r.addr = addr_i;
					next_r.sel_n = 1'b0;
					next_r.sel = 1'b1;
					t_load = 1'b1;
					if (write_i) begin
						// Output enable stays high, so the memory is floating
						next_r.wdata = wdata_i;
						next_r.data_oe = 1'b1;
						next_r.we_n = 1'b0;
						t_val = SRAC_LD_STROBE;
						next_r.state = SRAC_WR_PULSE;
					end else begin
						next_r.oe_n = 1'b0;
						t_val = SRAC_LD_READ;
						next_r.state = SRAC_RD_WAIT;
					end
				end
			end
			SRAC_WR_PULSE: begin
				if (t_done) begin
					// The strobe alone ends the write; data and address still held
					next_r.we_n = 1'b1;
					t_load = 1'b1;
					t_val = SRAC_LD_HOLD;
					next_r.state = SRAC_WR_HOLD;
				end
			end
			SRAC_WR_HOLD: begin
				if (t_done) begin
					next_r.sel_n = 1'b1;
					next_r.sel = 1'b0;
					next_r.data_oe = 1'b0;
					t_load = 1'b1;
					t_val = SRAC_LD_FLOAT;
					next_r.state = SRAC_TURN;
				end
			end
			SRAC_RD_WAIT: begin
				if (t_done) begin
					// Sampled after the access time plus the synchroniser delay
					next_r.rdata = r.sync2;
					next_r.rvalid = 1'b1;
					next_r.oe_n = 1'b1;
					next_r.sel_n = 1'b1;
					next_r.sel = 1'b0;
					t_load = 1'b1;
					t_val = SRAC_LD_FLOAT;
					next_r.state = SRAC_TURN;
				end
			end
			SRAC_TURN: begin
				// Wait for the memory drivers to float before anything new
				if (t_done) begin
					next_r.state = SRAC_IDLE;
				end
			end
			SRAC_SLEEP: begin
				if (!sleep_i) begin
					t_load = 1'b1;
					t_val = SRAC_LD_RECOVERY;
					next_r.state = SRAC_WAKE;
				end
			end
			SRAC_WAKE: begin
				if (t_done) begin
					next_r.state = SRAC_IDLE;
				end
			end
			default: begin
				next_r = SRAC_RST;
			end
		endcase
	end

	// State register; the clock enable freezes everything
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			r <= SRAC_RST;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	// Ready and asleep are decoded combinationally, rvalid and data come straight from flops
	assign ready_o = (r.state == SRAC_IDLE) && !sleep_i;
	assign asleep_o = (r.state == SRAC_SLEEP);
	assign rdata_o = r.rdata;
	assign rvalid_o = r.rvalid;
	assign mem_addr_o = r.addr;
	assign select_low_active_n_o = r.sel_n;
	assign select_high_active_o = r.sel;
	assign write_strobe_n_o = r.we_n;
	assign output_enable_n_o = r.oe_n;
	assign mem_data_o = r.wdata;
	assign mem_data_oe_o = r.data_oe;

endmodule : srac_host

// file: logic/srac_pkg.sv
// Constants for the host-side controller of an asynchronous byte-wide SRAM.
// Assumes a 200 MHz system clock; every pin time is rounded to whole cycles.
package srac_pkg;

	// Pin and timer widths
	localparam int SRAC_ADDR_W = 20;
	localparam int SRAC_DATA_W = 8;
	localparam int SRAC_CNT_W = 4;

	// Clock period and pin times in ns, as printed
	localparam int SRAC_CLK_NS = 5;
	localparam int SRAC_READ_CYCLE_MIN_NS = 45;
	localparam int SRAC_ADDRESS_TO_READ_VALID_NS = 45;
	localparam int SRAC_OUTPUT_ENABLE_TO_FLOAT_NS = 18;
	localparam int SRAC_WRITE_CYCLE_MIN_NS = 45;
	localparam int SRAC_WRITE_STROBE_WIDTH_NS = 35;
	localparam int SRAC_WRITE_DATA_SETUP_NS = 25;
	localparam int SRAC_WRITE_DATA_HOLD_NS = 0;
	localparam int SRAC_RETENTION_RECOVERY_NS = 45;

	// Cycle counts: waits on minimum times round up, maximum delays we wait out round up too
	localparam int SRAC_SYNC_STAGES = 2;
	localparam int SRAC_READ_VALID_CYC =
		(SRAC_ADDRESS_TO_READ_VALID_NS + SRAC_CLK_NS - 1) / SRAC_CLK_NS;
	localparam int SRAC_READ_CYC = SRAC_READ_VALID_CYC + SRAC_SYNC_STAGES + 1;
	localparam int SRAC_FLOAT_CYC =
		(SRAC_OUTPUT_ENABLE_TO_FLOAT_NS + SRAC_CLK_NS - 1) / SRAC_CLK_NS;
	localparam int SRAC_STROBE_CYC =
		(SRAC_WRITE_STROBE_WIDTH_NS + SRAC_CLK_NS - 1) / SRAC_CLK_NS;
	localparam int SRAC_HOLD_CYC = 1;
	localparam int SRAC_RECOVERY_CYC =
		(SRAC_RETENTION_RECOVERY_NS + SRAC_CLK_NS - 1) / SRAC_CLK_NS;

	// Timer load values (a state lasts load + 1 cycles)
	localparam logic [SRAC_CNT_W-1:0] SRAC_LD_READ = SRAC_CNT_W'(SRAC_READ_CYC - 1);
	localparam logic [SRAC_CNT_W-1:0] SRAC_LD_FLOAT = SRAC_CNT_W'(SRAC_FLOAT_CYC - 1);
	localparam logic [SRAC_CNT_W-1:0] SRAC_LD_STROBE = SRAC_CNT_W'(SRAC_STROBE_CYC - 1);
	localparam logic [SRAC_CNT_W-1:0] SRAC_LD_HOLD = SRAC_CNT_W'(SRAC_HOLD_CYC - 1);
	localparam logic [SRAC_CNT_W-1:0] SRAC_LD_RECOVERY = SRAC_CNT_W'(SRAC_RECOVERY_CYC - 1);

	// Access sequencer states, Gray coded along the write path
	typedef enum logic [2:0] {
		SRAC_IDLE = 3'h0,
		SRAC_WR_PULSE = 3'h1,
		SRAC_WR_HOLD = 3'h3,
		SRAC_TURN = 3'h2,
		SRAC_RD_WAIT = 3'h6,
		SRAC_SLEEP = 3'h7,
		SRAC_WAKE = 3'h5
	} srac_state_t;

endpackage : srac_pkg

// file: logic/srac_timer.sv
// Down-counting phase timer for the SRAM access sequencer.
// Assumes the caller loads it on entry to each timed state and reads done_o.
`timescale 1ns/1ps
module srac_timer #(
	parameter int CNT_W = 4
) (
	// Clock and control
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Load and status
	input wire logic load_i,
	input wire logic [CNT_W-1:0] value_i,
	output logic done_o
);

	typedef struct packed {
		logic [CNT_W-1:0] count;
	} srac_timer_t;

	srac_timer_t r;
	srac_timer_t next_r;

	initial begin
		if (CNT_W < 1) begin
			$error("srac_timer: CNT_W must be at least 1");
		end
	end

	// Load wins over counting; count parks at zero
	always_comb begin
		next_r = r;
		if (load_i) begin
			next_r.count = value_i;
		end else if (r.count != '0) begin
			next_r.count = r.count - CNT_W'(1);
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			r <= '0;
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	assign done_o = (r.count == '0); // From a register

endmodule : srac_timer

// file: dv/srac_sram.sv
// Behavioural byte-wide asynchronous SRAM on the far side of the host pins.
// Assumes the bench resolves the shared data bus from both drivers.
`timescale 1ns/1ps
module srac_sram (
	// Pins from the host
	input wire logic [19:0] addr_i,
	input wire logic sel_n_i,
	input wire logic sel_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic [7:0] d_i,
	// Data the memory drives
	output logic [7:0] q_o
);
	logic [7:0] mem [int];
	logic [7:0] last = 8'h00;
	logic [7:0] q;
	// Write lasts exactly as long as all three qualifiers overlap
	wire wr = !sel_n_i && sel_i && !we_n_i;
	// Stored as the overlap ends, whichever pin ends it
	always @(negedge wr) if ($time > 0) mem[addr_i] = d_i;
	// Off the bus it shows the inverse of the last value, so a stale read cannot pass
	always @(*) begin
		if (!sel_n_i && sel_i && we_n_i && !oe_n_i) begin
			q = mem.exists(addr_i) ? mem[addr_i] : 8'h00;
			last = q;
		end else q = ~last;
	end
	// Answers and floats 22 ns after the pins change
	assign #22 q_o = q;
endmodule : srac_sram

// file: dv/srac_chk_assertions.sv
// Pin-level checks of the host controller against the SRAM timing.
// Assumes it is bound into srac_host and sees only that module's ports.
`timescale 1ns/1ps
module srac_chk #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 8
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Pins watched
	input wire logic [ADDR_W-1:0] mem_addr_o,
	input wire logic select_low_active_n_o,
	input wire logic select_high_active_o,
	input wire logic write_strobe_n_o,
	input wire logic output_enable_n_o,
	input wire logic [DATA_W-1:0] mem_data_o,
	input wire logic mem_data_oe_o,
	input wire logic rvalid_o,
	input wire logic asleep_o
);
	// One domain: one clock and reset for all
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	wire sel = !select_low_active_n_o && select_high_active_o;
	// Reset check stays live while reset is asserted
	property p_rst; @(posedge clk_sys_i) disable iff (1'b0) sys_rst_i |=> !sel &&
		write_strobe_n_o && output_enable_n_o && !mem_data_oe_o; endproperty
	a_rst: assert property (p_rst) else $error("pins not idle in reset");
	property p_wq; !write_strobe_n_o |-> sel && mem_data_oe_o && output_enable_n_o; endproperty
	a_wq: assert property (p_wq) else $error("strobe without qualifiers");
	property p_pwe; $fell(write_strobe_n_o) |-> !write_strobe_n_o [*7]; endproperty
	a_pwe: assert property (p_pwe) else $error("strobe too short");
	property p_wc; $fell(write_strobe_n_o) |=> !$fell(write_strobe_n_o) [*8]; endproperty
	a_wc: assert property (p_wc) else $error("write cycle too short");
	property p_hold; $rose(write_strobe_n_o) |-> sel && mem_data_oe_o &&
		$stable(mem_data_o) && $stable(mem_addr_o); endproperty
	a_hold: assert property (p_hold) else $error("no hold after write");
	property p_addr; sel && $past(sel) |-> $stable(mem_addr_o); endproperty
	a_addr: assert property (p_addr) else $error("address moved");
	property p_turn; $rose(output_enable_n_o) |-> !mem_data_oe_o [*4]; endproperty
	a_turn: assert property (p_turn) else $error("bus fight");
	property p_ret; $fell(asleep_o) |-> !sel [*8]; endproperty
	a_ret: assert property (p_ret) else $error("early access after wake");
	c_wr: cover property ($fell(write_strobe_n_o));
	c_rd: cover property (rvalid_o);
	c_sl: cover property ($fell(asleep_o));
endmodule : srac_chk
bind srac_host srac_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.clk_sys_i, .sys_rst_i,
	.mem_addr_o, .select_low_active_n_o, .select_high_active_o, .write_strobe_n_o,
	.output_enable_n_o, .mem_data_o, .mem_data_oe_o, .rvalid_o, .asleep_o);

// file: dv/test_async_sram_access_timing.sv
// Self-checking bench: host controller, behavioural SRAM, reference memory.
// Assumes the 200 MHz clock and the design's default widths.
`timescale 1ns/1ps
module test_async_sram_access_timing;
	logic clk_sys_i = 0, sys_rst_i = 1, ce_i = 1, req_i = 0, write_i = 0, sleep_i = 0;
	logic [19:0] addr_i = 20'h0;
	logic [7:0] wdata_i = 8'h00;
	wire ready_o, rvalid_o, asleep_o, sln, sh, wen, oen, doe;
	wire [7:0] rdata_o, dout, q, din;
	wire [19:0] ma;
	int seed = 32'h1f77adfe, miscompares = 0, checked = 0, cyc = 0, n;
	logic [7:0] ref_mem [int];
	logic [19:0] a;
	// Board resolves the shared data bus
	assign din = doe ? dout : q;
	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	srac_host DUT (.clk_sys_i, .sys_rst_i, .ce_i, .req_i, .write_i, .addr_i, .wdata_i,
		.ready_o, .rdata_o, .rvalid_o, .sleep_i, .asleep_o, .mem_addr_o(ma),
		.select_low_active_n_o(sln), .select_high_active_o(sh), .write_strobe_n_o(wen),
		.output_enable_n_o(oen), .mem_data_i(din), .mem_data_o(dout), .mem_data_oe_o(doe));
	srac_sram mem (.addr_i(ma), .sel_n_i(sln), .sel_i(sh), .we_n_i(wen), .oe_n_i(oen),
		.d_i(dout), .q_o(q));
	// Every wait passes here; clock enable stalls at random
	task automatic step;
		@(negedge clk_sys_i);
		ce_i = ($random(seed) % 6) != 0;
	endtask : step
	task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string m);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : cmp
	// One access, held until taken; reads are compared with the reference
	task automatic access(input bit w, input logic [19:0] ad, input logic [7:0] d);
		bit tk;
		tk = 0;
		req_i = 1;
		write_i = w;
		addr_i = ad;
		wdata_i = d;
		for (n = 0; n < 200 && !tk; n++) begin
			tk = (ready_o === 1'b1) && ce_i;
			step();
		end
		req_i = 0;
		cmp(8'(tk), 8'h01, "request taken");
		if (w) begin
			// Let an edge pass so the next call never raises the request in this step
			ref_mem[ad] = d;
			step();
		end else begin
			for (n = 0; n < 200 && rvalid_o !== 1'b1; n++) step();
			cmp(8'(rvalid_o === 1'b1), 8'h01, "read valid");
			cmp(rdata_o, ref_mem.exists(ad) ? ref_mem[ad] : 8'h00, "read data");
		end
	endtask : access
	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// Hang guard
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end
	initial begin
		repeat (10) step();
		sys_rst_i = 0;
		for (int i = 0; i < 16; i++) begin
			a = (i < 2) ? {20{i[0]}} : 20'($random(seed));
			access(1, a, 8'($random(seed)));
			access(0, a, 8'h00);
		end
		foreach (ref_mem[k]) access(0, 20'(k), 8'h00);
		$display("test write_read done");
		sleep_i = 1;
		for (n = 0; n < 50 && asleep_o !== 1'b1; n++) step();
		req_i = 1;
		write_i = 1;
		addr_i = 20'h0;
		wdata_i = 8'h5a;
		repeat (20) step();
		cmp({4'h0, asleep_o, sln, sh, ready_o}, 8'h0c, "asleep pins");
		req_i = 0;
		sleep_i = 0;
		for (n = 0; n < 50 && ready_o !== 1'b1; n++) step();
		cmp({6'h0, n >= 9, ready_o}, 8'h03, "woke early");
		access(0, 20'h0, 8'h00);
		$display("test retention done");
		req_i = 1;
		write_i = 1;
		addr_i = 20'h00abc;
		wdata_i = 8'hc3;
		for (n = 0; n < 50 && wen !== 1'b0; n++) step();
		req_i = 0;
		sys_rst_i = 1;
		step();
		step();
		cmp({3'h0, sln, sh, wen, oen, doe}, 8'h16, "reset pins");
		sys_rst_i = 0;
		access(1, 20'h00abc, 8'h3c);
		access(0, 20'h00abc, 8'h00);
		$display("test reset done");
		report_and_stop();
	end
endmodule : test_async_sram_access_timing
